// *** e1_alarm_pkg.sv ***
package e1_alarm_pkg;
  localparam logic [7:0] ADDR_VIOL_HIGH    = 8'h00;
  localparam logic [7:0] ADDR_VIOL_LOW     = 8'h01;
  localparam logic [7:0] ADDR_CRC_HIGH     = 8'h02;
  localparam logic [7:0] ADDR_CRC_LOW      = 8'h03;
  localparam logic [7:0] ADDR_FEBE_HIGH    = 8'h04;
  localparam logic [7:0] ADDR_FEBE_LOW     = 8'h05;
  localparam logic [7:0] ADDR_ALARM_STATUS = 8'h06;
  localparam logic [7:0] ADDR_EVENT_STATUS = 8'h07;
  localparam logic [7:0] ADDR_ALARM_MASK   = 8'h16;
  localparam logic [7:0] ADDR_EVENT_MASK   = 8'h17;
  localparam logic [7:0] ADDR_SYNC_STATE   = 8'h1E;
  localparam logic [7:0] MASK_RESET        = 8'h00;
  localparam int CLK_MHZ        = 200;
  localparam int SEC_US         = 1000000;
  localparam int FAST_US        = 62500;
  localparam int SEC_CYCLES     = SEC_US * CLK_MHZ;
  localparam int FAST_CYCLES    = FAST_US * CLK_MHZ;
  localparam int CRC_SEARCH_US  = 8000;
  localparam int CRC_SEARCH_CYC = CRC_SEARCH_US * CLK_MHZ;
  localparam int RX_SIGNALING_ALL_ONES_ZEROS     = 3;
  localparam int RX_UNFRAMED_ONES_BITS      = 512;
  localparam int RX_UNFRAMED_ONES_ZEROS     = 3;
  localparam int RRA_RUN        = 3;
  localparam int RCL_ZEROS      = 255;
  localparam int RCL_ONES       = 32;
  localparam int RX_DISTANT_MF_ALARM_RUN       = 2;
  localparam logic [15:0] VIOL_MAX = 16'hFFFF;
endpackage : e1_alarm_pkg

// *** e1_ctr_if.sv ***
`timescale 1ns/1ps
interface e1_ctr_if;
  logic       inc;
  logic       clr;
  logic [9:0] count;
  modport owner (input inc, input clr, output count);
  modport user  (output inc, output clr, input count);
endinterface : e1_ctr_if

// *** e1_err_counter.sv ***
`timescale 1ns/1ps
module e1_err_counter (
  input wire logic clk,
  input wire logic rstN,
  e1_ctr_if.owner  port
);
  logic [9:0] cnt_q;
  // restart on boundary but keep the coincident event
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) cnt_q <= 10'h000;
    else if (port.clr) cnt_q <= {9'h000, port.inc}; // [R24]
    else if (port.inc) cnt_q <= cnt_q + 10'h001;
  end
  assign port.count = cnt_q;
endmodule : e1_err_counter

// *** e1_alarm_status_counters.sv ***
`timescale 1ns/1ps
// Overview of operation
// [R01] six-bit search counter steps on each 8 ms CRC4 search timeout
// [R02] search counter clears on CRC4 sync or mode off, else wraps
// [R03] sync state byte: counter bits 5..2, bit 0, three live search flags
// [R04] signaling all-ones alarm: under 3 zeros per multiframe sets, 3+ clears
// [R05] signaling all-zeros alarm: all zero multiframe sets, any one clears
// [R06] distant multiframe alarm: two multiframes set, two clear
// [R07] unframed all-ones: under 3 zeros in 512 bits sets, more clears
// [R08] remote alarm: bit 3 of non-align frame thrice sets, thrice clears
// [R09] carrier loss after 255 zeros; cleared by 32 ones within 255 bits
// [R10] loss-of-sync flag in alarm status bit 0 while unsynchronized
// [R11] mask bit one passes the matching status event, zero blocks it
// [R12] counters update each second or each 62.5 ms; same tick sets flag
// [R13] host reads counters within one update interval
// [R14] bipolar violations counted, HDB3 substitutions excluded when enabled
// [R15] select one counts code violations instead
// [R16] violation counter always counts and saturates at 65535
// [R17] violation count split into high and low bytes
// [R18] CRC count in bits 9..0; top six bits carry FAS count MSBs
// [R19] CRC and E-bit counters halt on FAS or CRC4 sync loss
// [R20] E-bit counter counts zero E bits of frames 13 and 15
// [R21] E-bit count in bits 9..0; top six bits carry FAS count LSBs
// [R22] status bits latch; masked write refreshes read copy and clears
// [R23] alarm status drives irq one, event status drives irq two
// [R24] on update, counter copied and restarted in the same cycle
module e1_alarm_status_counters
  import e1_alarm_pkg::*;
#(
  parameter int SEC_CNT  = SEC_CYCLES,
  parameter int FAST_CNT = FAST_CYCLES,
  parameter int SRCH_CNT = CRC_SEARCH_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        bitEn,
  input  wire logic        rxBit,
  input  wire logic        bpvEvt,
  input  wire logic        hdb3Sub,
  input  wire logic        cvEvt,
  input  wire logic        ts16Bit,
  input  wire logic        mfEnd,
  input  wire logic        frame0Bit6,
  input  wire logic        nafBit3,
  input  wire logic        nafEn,
  input  wire logic        crcErr,
  input  wire logic        eBitEn,
  input  wire logic        eBitVal,
  input  wire logic [11:0] fasCount,
  input  wire logic        frame_align_searching,
  input  wire logic        signaling_mf_searching,
  input  wire logic        crc_mf_searching,
  input  wire logic        crcSyncOk,
  input  wire logic        rx_elastic_slip,
  input  wire logic [7:0]  frameEvents,
  input  wire logic        crcModeEn,
  input  wire logic        hdb3En,
  input  wire logic        violSel,
  input  wire logic        fastUpdate,
  input  wire logic        wrEn,
  input  wire logic        rdEn,
  input  wire logic [7:0]  addr,
  input  wire logic [7:0]  wrData,
  output logic      [7:0]  rdData,
  output logic             irq_out_one,
  output logic             irq_out_two
);
  typedef enum logic [2:0] {
    ALM_CLEAR = 3'b001, ALM_SET = 3'b010, ALM_HOLD = 3'b100
  } alm_t;

  logic rs1_q, rstN;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) {rstN, rs1_q} <= 2'b00;
    else {rstN, rs1_q} <= {rs1_q, 1'b1};
  end

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
    return a == ref_a;
  endfunction : hit

  // update timer
  logic [31:0] tmr_q;
  logic [31:0] tmrLimit;
  logic        tick;
  assign tmrLimit = fastUpdate ? 32'(FAST_CNT - 1) : 32'(SEC_CNT - 1);
  assign tick     = tmr_q >= tmrLimit;
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) tmr_q <= 32'h0;
    else tmr_q <= tick ? 32'h0 : tmr_q + 32'h1; // [R12]
  end

  // search timer and counter
  logic [31:0] srch_q;
  logic        srchTo;
  logic [5:0]  csc_q;
  assign srchTo = crc_mf_searching && srch_q == 32'(SRCH_CNT - 1);
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) srch_q <= 32'h0;
    else if (!crc_mf_searching || srchTo) srch_q <= 32'h0;
    else srch_q <= srch_q + 32'h1;
  end
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) csc_q <= 6'h00;
    else if (crcSyncOk || !crcModeEn) csc_q <= 6'h00; // [R02]
    else if (srchTo) csc_q <= csc_q + 6'h01; // [R01] [R02]
  end
  logic [7:0] syncState;
  assign syncState = {csc_q[5:2], csc_q[0], frame_align_searching,
                      signaling_mf_searching, crc_mf_searching}; // [R03]

  // ts16 multiframe zero count
  logic [4:0] tsZero_q;
  logic [4:0] tsZeroNow;
  logic       sa1_q, sa0_q;
  assign tsZeroNow = tsZero_q + {4'h0, bitEn & ~ts16Bit};
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) tsZero_q <= 5'h00;
    else if (mfEnd) tsZero_q <= 5'h00;
    else if (bitEn && !ts16Bit && tsZero_q != 5'h1F) tsZero_q <= tsZeroNow;
  end
  logic [4:0] tsOnes_q;
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) tsOnes_q <= 5'h00;
    else if (mfEnd) tsOnes_q <= 5'h00;
    else if (bitEn && ts16Bit) tsOnes_q <= 5'h01;
  end
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      sa1_q <= 1'b0;
      sa0_q <= 1'b0;
    end else if (mfEnd) begin
      sa1_q <= tsZero_q < 5'(RX_SIGNALING_ALL_ONES_ZEROS); // [R04]
      sa0_q <= tsOnes_q == 5'h00; // [R05]
    end
  end

  // distant multiframe alarm, small state machine
  alm_t dma_q, dmaNext;
  logic dmaPrev_q;
  always_comb begin
    dmaNext = dma_q;
    case (dma_q)
      ALM_CLEAR: if (mfEnd && frame0Bit6 && dmaPrev_q) dmaNext = ALM_SET;
      ALM_SET:   if (mfEnd && !frame0Bit6 && !dmaPrev_q) dmaNext = ALM_CLEAR;
      ALM_HOLD:  dmaNext = ALM_CLEAR;
      default:   dmaNext = ALM_CLEAR;
    endcase
  end
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      dma_q     <= ALM_CLEAR;
      dmaPrev_q <= 1'b0;
    end else if (mfEnd) begin
      dma_q     <= dmaNext; // [R06]
      dmaPrev_q <= frame0Bit6;
    end
  end

  // unframed all ones over 512 bit window
  logic [8:0] uaBits_q;
  logic [1:0] uaZeros_q;
  logic       ua1_q;
  logic       uaEnd;
  assign uaEnd = bitEn && uaBits_q == 9'(RX_UNFRAMED_ONES_BITS - 1);
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      uaBits_q  <= 9'h000;
      uaZeros_q <= 2'h0;
      ua1_q     <= 1'b0;
    end else if (uaEnd) begin
      uaBits_q  <= 9'h000;
      uaZeros_q <= 2'h0;
      // one spare bit so a saturated zero count cannot wrap back under the limit
      ua1_q     <= ({1'b0, uaZeros_q} + {2'b00, ~rxBit}) < 3'(RX_UNFRAMED_ONES_ZEROS); // [R07]
    end else if (bitEn) begin
      uaBits_q  <= uaBits_q + 9'h001;
      if (!rxBit && uaZeros_q != 2'h3) uaZeros_q <= uaZeros_q + 2'h1;
    end
  end

  // remote alarm, 3 in a row
  logic [1:0] raRun_q;
  logic       raVal_q, ra_q;
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      raRun_q <= 2'h0;
      raVal_q <= 1'b0;
      ra_q    <= 1'b0;
    end else if (nafEn) begin
      raVal_q <= nafBit3;
      raRun_q <= (nafBit3 == raVal_q && raRun_q != 2'h3) ? raRun_q + 2'h1 : 2'h1;
      if (nafBit3 == raVal_q && raRun_q == 2'(RRA_RUN - 1)) ra_q <= nafBit3; // [R08]
    end
  end

  // carrier loss
  logic [7:0] clZero_q, clWin_q;
  logic [5:0] clOnes_q;
  logic       cl_q;
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      clZero_q <= 8'h00;
      clWin_q  <= 8'h00;
      clOnes_q <= 6'h00;
      cl_q     <= 1'b0;
    end else if (bitEn) begin
      clZero_q <= rxBit ? 8'h00 : (clZero_q == 8'hFF ? 8'hFF : clZero_q + 8'h01);
      if (!rxBit && clZero_q == 8'(RCL_ZEROS - 1)) cl_q <= 1'b1; // [R09]
      if (clWin_q == 8'(RCL_ZEROS - 1)) begin
        clWin_q  <= 8'h00;
        clOnes_q <= 6'h00;
        if ({1'b0, clOnes_q} + {6'h00, rxBit} >= 7'(RCL_ONES)) cl_q <= 1'b0; // [R09]
      end else begin
        clWin_q  <= clWin_q + 8'h01;
        if (rxBit && clOnes_q != 6'h3F) clOnes_q <= clOnes_q + 6'h01;
      end
    end
  end

  // error counters
  logic [15:0] viol_q, violHold_q;
  logic        violEvt;
  assign violEvt = violSel ? cvEvt : (bpvEvt && !(hdb3En && hdb3Sub)); // [R14] [R15]
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) viol_q <= 16'h0;
    else if (tick) viol_q <= {15'h0, violEvt}; // [R24]
    else if (violEvt && viol_q != VIOL_MAX) viol_q <= viol_q + 16'h1; // [R16]
  end
  logic syncLost;
  assign syncLost = frame_align_searching || crc_mf_searching;
  e1_ctr_if crcIf ();
  e1_ctr_if ebIf ();
  assign crcIf.inc = crcErr && !syncLost; // [R19]
  assign crcIf.clr = tick;
  assign ebIf.inc  = eBitEn && !eBitVal && !syncLost; // [R19] [R20]
  assign ebIf.clr  = tick;
  e1_err_counter uCrc (.clk(clk), .rstN(rstN), .port(crcIf.owner));
  e1_err_counter uEb  (.clk(clk), .rstN(rstN), .port(ebIf.owner));
  logic [9:0] crcHold_q, ebHold_q;
  logic [11:0] fasHold_q;
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      violHold_q <= 16'h0;
      crcHold_q  <= 10'h0;
      ebHold_q   <= 10'h0;
      fasHold_q  <= 12'h0;
    end else if (tick) begin
      violHold_q <= viol_q; // [R12] [R24]
      crcHold_q  <= crcIf.count;
      ebHold_q   <= ebIf.count;
      fasHold_q  <= fasCount;
    end
  end

  // latched status
  logic [7:0] almLive, evtLive;
  assign almLive = {sa1_q, dma_q == ALM_SET, sa0_q, rx_elastic_slip, ua1_q,
                    ra_q, cl_q, frame_align_searching}; // [R10]
  assign evtLive = {frameEvents[7:5], tick, frameEvents[3:0]}; // [R12]
  logic [7:0] almLat_q, evtLat_q, almRd_q, evtRd_q, almMask_q, evtMask_q;
  logic wrAlm, wrEvt;
  assign wrAlm = wrEn && hit(addr, ADDR_ALARM_STATUS);
  assign wrEvt = wrEn && hit(addr, ADDR_EVENT_STATUS);
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      almLat_q <= 8'h00;
      evtLat_q <= 8'h00;
      almRd_q  <= 8'h00;
      evtRd_q  <= 8'h00;
    end else begin
      // set beats clear for a coincident event
      almLat_q <= (almLat_q & ~(wrAlm ? wrData : 8'h00)) | almLive; // [R22]
      evtLat_q <= (evtLat_q & ~(wrEvt ? wrData : 8'h00)) | evtLive; // [R22]
      if (wrAlm) almRd_q <= (almRd_q & ~wrData) | (almLat_q & wrData);
      if (wrEvt) evtRd_q <= (evtRd_q & ~wrData) | (evtLat_q & wrData);
    end
  end
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      almMask_q <= MASK_RESET;
      evtMask_q <= MASK_RESET;
    end else if (wrEn) begin
      if (hit(addr, ADDR_ALARM_MASK)) almMask_q <= wrData;
      if (hit(addr, ADDR_EVENT_MASK)) evtMask_q <= wrData;
    end
  end
  assign irq_out_one = |(almLat_q & almMask_q); // [R11] [R23]
  assign irq_out_two = |(evtLat_q & evtMask_q); // [R11] [R23]

  // read mux, registered
  logic [7:0] rdNext;
  always_comb begin
    case (addr)
      ADDR_VIOL_HIGH:    rdNext = violHold_q[15:8]; // [R17]
      ADDR_VIOL_LOW:     rdNext = violHold_q[7:0];
      ADDR_CRC_HIGH:     rdNext = {fasHold_q[11:6], crcHold_q[9:8]}; // [R18]
      ADDR_CRC_LOW:      rdNext = crcHold_q[7:0];
      ADDR_FEBE_HIGH:    rdNext = {fasHold_q[5:0], ebHold_q[9:8]}; // [R21]
      ADDR_FEBE_LOW:     rdNext = ebHold_q[7:0];
      ADDR_ALARM_STATUS: rdNext = almRd_q;
      ADDR_EVENT_STATUS: rdNext = evtRd_q;
      ADDR_ALARM_MASK:   rdNext = almMask_q;
      ADDR_EVENT_MASK:   rdNext = evtMask_q;
      ADDR_SYNC_STATE:   rdNext = syncState;
      default:           rdNext = 8'h00;
    endcase
  end
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) rdData <= 8'h00;
    else if (rdEn) rdData <= rdNext;
  end

  // checks
  a_viol_saturates: assert property (@(posedge clk) disable iff (!rstN) // [R16]
    viol_q == VIOL_MAX && !tick |=> viol_q == VIOL_MAX) else $error("viol wrapped");
  a_csc_clears: assert property (@(posedge clk) disable iff (!rstN) // [R02]
    !crcModeEn |=> csc_q == 6'h00) else $error("search count not cleared");
  a_csc_steps: assert property (@(posedge clk) disable iff (!rstN) // [R01]
    srchTo && crcModeEn && !crcSyncOk |=> csc_q == $past(csc_q) + 6'h01)
    else $error("search count not stepped");
  a_irq_one_gate: assert property (@(posedge clk) disable iff (!rstN) // [R11]
    almMask_q == 8'h00 |-> !irq_out_one) else $error("masked irq one");
  a_lat_holds: assert property (@(posedge clk) disable iff (!rstN) // [R22]
    almLat_q[0] && !wrAlm |=> almLat_q[0]) else $error("status bit lost");
  a_los_flag: assert property (@(posedge clk) disable iff (!rstN) // [R10]
    frame_align_searching |=> almLat_q[0]) else $error("sync loss not flagged");
  a_crc_halt: assert property (@(posedge clk) disable iff (!rstN) // [R19]
    syncLost && !tick |=> crcIf.count == $past(crcIf.count)) else $error("crc counted");
  a_hold_copy: assert property (@(posedge clk) disable iff (!rstN) // [R24]
    tick |=> violHold_q == $past(viol_q) && crcHold_q == $past(crcIf.count))
    else $error("hold not copied");
  a_cl_sets: assert property (@(posedge clk) disable iff (!rstN) // [R09]
    bitEn && !rxBit && clZero_q == 8'(RCL_ZEROS - 1) |=> cl_q) else $error("no carrier loss");
  a_ua_clear: assert property (@(posedge clk) disable iff (!rstN) // [R07]
    uaEnd && uaZeros_q == 2'h3 |=> !ua1_q) else $error("unframed ones kept");
  a_cl_clear: assert property (@(posedge clk) disable iff (!rstN) // [R09]
    bitEn && clWin_q == 8'(RCL_ZEROS - 1) && clOnes_q == 6'h3F |=> !cl_q)
    else $error("carrier loss kept");
  c_tick: cover property (@(posedge clk) disable iff (!rstN) tick);
  c_cl_set: cover property (@(posedge clk) disable iff (!rstN) cl_q);
  c_irq_one: cover property (@(posedge clk) disable iff (!rstN) irq_out_one);
  c_dma_set: cover property (@(posedge clk) disable iff (!rstN) dma_q == ALM_SET);
endmodule : e1_alarm_status_counters

// *** host.sv ***
`timescale 1ns/1ps
module host (
  input  wire logic       clk,
  output logic            wrEn,
  output logic            rdEn,
  output logic [7:0]      addr,
  output logic [7:0]      wrData,
  input  wire logic [7:0] rdData
);
  initial begin
    {wrEn, rdEn, addr, wrData} = '0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    #1;
    wrEn   = 1'b1;
    addr   = a;
    wrData = v;
    @(posedge clk);
    #1;
    wrEn   = 1'b0;
    // released data must not keep echoing the last value
    wrData = ~v;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    #1;
    rdEn = 1'b1;
    addr = a;
    @(posedge clk);
    #1;
    rdEn = 1'b0;
    @(posedge clk);
    #1;
    v = rdData;
  endtask : rd

  // events race the port, so the bits just read are written back to clear them
  task automatic status(input logic [7:0] a, input logic [7:0] m, output logic [7:0] v);
    wr(a, m);
    rd(a, v);
    wr(a, v & m);
  endtask : status
endmodule : host

// *** testbench.sv ***
`timescale 1ns/1ps
module testbench;
  import e1_alarm_pkg::*;
  localparam logic [11:0] FAS = 12'hABC;
  typedef struct {
    int fa, sg, cs, vs, hd, nB, nS, nC, nR, nE0, nE1, eV, eR, eE;
  } row_t;
  // per interval: search flags, selects, event counts, then expected counts
  row_t rows [7] = '{
    '{0, 0, 0, 0, 0, 7, 0, 2, 5, 3, 2, 7, 5, 3},
    '{0, 0, 0, 0, 1, 4, 3, 0, 0, 0, 0, 4, 0, 0},
    '{0, 0, 0, 0, 0, 4, 3, 0, 0, 0, 0, 7, 0, 0},
    '{0, 0, 0, 1, 0, 3, 0, 6, 0, 0, 0, 6, 0, 0},
    '{1, 0, 0, 0, 0, 2, 0, 0, 4, 2, 0, 2, 0, 0},
    '{0, 0, 1, 0, 0, 2, 0, 0, 4, 2, 0, 2, 0, 0},
    '{0, 1, 0, 0, 0, 0, 0, 0, 4, 2, 1, 0, 4, 2}
  };
  logic       clk, rst_n, bitEn, rxBit, bpvEvt, hdb3Sub, cvEvt, ts16Bit, mfEnd;
  logic       frame0Bit6, nafBit3, nafEn, crcErr, eBitEn, eBitVal, fa, sg, cs;
  logic       crcSyncOk, crcModeEn, hdb3En, violSel, fastUpdate, wrEn, rdEn, irq1, irq2;
  logic [7:0] addr, wrData, rdData, d;
  logic [7:0] want [6];
  logic [15:0] v;
  logic [9:0] c, e;
  int         n_errors, n_compared, k;

  always #2.5 clk = ~clk;

  // short counts keep the run brief; 66000 still lets the violation count saturate
  e1_alarm_status_counters #(.SEC_CNT(66000), .FAST_CNT(200), .SRCH_CNT(10))
    e1_alarm_status_counters_i (
    .clk, .rst_n, .bitEn, .rxBit, .bpvEvt, .hdb3Sub, .cvEvt, .ts16Bit, .mfEnd,
    .frame0Bit6, .nafBit3, .nafEn, .crcErr, .eBitEn, .eBitVal, .crcSyncOk,
    .fasCount(FAS), .frame_align_searching(fa), .signaling_mf_searching(sg),
    .crc_mf_searching(cs), .rx_elastic_slip(1'b0), .frameEvents(8'h00),
    .crcModeEn, .hdb3En, .violSel, .fastUpdate, .wrEn, .rdEn, .addr, .wrData,
    .rdData, .irq_out_one(irq1), .irq_out_two(irq2));

  host host_i (.clk(clk), .wrEn(wrEn), .rdEn(rdEn), .addr(addr), .wrData(wrData),
    .rdData(rdData));

  task summarize;
    if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize

  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  // a gap cycle so the next burst never re-raises bitEn in the same step
  task bits(input int n, input logic b);
    rxBit = b;
    bitEn = 1'b1;
    cyc(n);
    bitEn = 1'b0;
    cyc(1);
  endtask : bits

  task mf(input logic ts, input logic b6);
    ts16Bit = ts;
    bits(16, 1'b1);
    frame0Bit6 = b6;
    mfEnd = 1'b1;
    cyc(1);
    mfEnd = 1'b0;
  endtask : mf

  task naf(input int n);
    repeat (n) begin
      nafEn = 1'b1;
      cyc(1);
      nafEn = 1'b0;
      cyc(1);
    end
  endtask : naf

  task st(input logic [7:0] a, input logic [7:0] m, input logic [7:0] x);
    host_i.status(a, m, d);
    chk(d & m, x);
  endtask : st

  task syncRd(input logic [7:0] x);
    host_i.rd(ADDR_SYNC_STATE, d);
    chk(d, x);
  endtask : syncRd

  // first poll only clears a stale tick; the wait then starts afresh
  task tick;
    int j;
    host_i.status(ADDR_EVENT_STATUS, 8'h10, d);
    d = 8'h00;
    for (j = 0; j < 100 && d[4] !== 1'b1; j++) host_i.status(ADDR_EVENT_STATUS, 8'h10, d);
    if (d[4] !== 1'b1) begin
      n_errors++;
      $display("unexpected at %0t: no update tick", $time);
      summarize();
    end
  endtask : tick

  initial begin
    {clk, rst_n, bitEn, rxBit, bpvEvt, hdb3Sub, cvEvt, ts16Bit, mfEnd, frame0Bit6} = '0;
    {nafBit3, nafEn, crcErr, eBitEn, eBitVal, fa, sg, cs, crcSyncOk} = '0;
    {crcModeEn, hdb3En, violSel, n_errors, n_compared} = '0;
    fastUpdate = 1'b1;
    cyc(6);
    chk({6'h00, irq2, irq1}, 8'h00);
    cyc(6);
    rst_n = 1'b1;
    cyc(4);
    host_i.rd(ADDR_EVENT_MASK, d);
    chk(d, MASK_RESET);
    host_i.wr(ADDR_ALARM_MASK, 8'hA5);
    host_i.rd(ADDR_ALARM_MASK, d);
    chk(d, 8'hA5);
    host_i.wr(8'h20, 8'h55);
    host_i.rd(8'h20, d);
    chk(d, 8'h00);
    host_i.wr(ADDR_SYNC_STATE, 8'hFF);
    syncRd(8'h00);
    {sg, cs, crcModeEn} = '1;
    cyc(42);
    syncRd(8'h13);
    crcModeEn = 1'b0;
    cyc(2);
    syncRd(8'h03);
    {crcModeEn, crcSyncOk} = '1;
    cyc(42);
    syncRd(8'h03);
    {sg, cs, fa} = 3'h1;
    cyc(2);
    syncRd(8'h04);
    st(ADDR_ALARM_STATUS, 8'h01, 8'h01);
    host_i.wr(ADDR_ALARM_MASK, 8'h01);
    chk({7'h00, irq1}, 8'h01);
    host_i.wr(ADDR_ALARM_MASK, 8'h00);
    chk({7'h00, irq1}, 8'h00);
    fa = 1'b0;
    st(ADDR_ALARM_STATUS, 8'h01, 8'h01);
    st(ADDR_ALARM_STATUS, 8'h01, 8'h00);
    bits(254, 1'b0);
    st(ADDR_ALARM_STATUS, 8'h02, 8'h00);
    bits(1, 1'b0);
    st(ADDR_ALARM_STATUS, 8'h02, 8'h02);
    bits(255, 1'b1);
    st(ADDR_ALARM_STATUS, 8'h02, 8'h02);
    st(ADDR_ALARM_STATUS, 8'h02, 8'h00);
    bits(1024, 1'b1);
    st(ADDR_ALARM_STATUS, 8'h08, 8'h08);
    host_i.status(ADDR_ALARM_STATUS, 8'hFF, d);
    mf(1'b0, 1'b1);
    st(ADDR_ALARM_STATUS, 8'hE0, 8'h20);
    mf(1'b1, 1'b1);
    st(ADDR_ALARM_STATUS, 8'hC0, 8'hC0);
    nafBit3 = 1'b1;
    naf(2);
    st(ADDR_ALARM_STATUS, 8'h04, 8'h00);
    naf(1);
    st(ADDR_ALARM_STATUS, 8'h04, 8'h04);
    foreach (rows[i]) begin
      tick();
      {fa, sg, cs} = {rows[i].fa != 0, rows[i].sg != 0, rows[i].cs != 0};
      {violSel, hdb3En} = {rows[i].vs != 0, rows[i].hd != 0};
      for (k = 0; k < 8; k++) begin
        bpvEvt  = k < rows[i].nB + rows[i].nS;
        hdb3Sub = k >= rows[i].nB && bpvEvt;
        cvEvt   = k < rows[i].nC;
        crcErr  = k < rows[i].nR;
        eBitEn  = k < rows[i].nE0 + rows[i].nE1;
        eBitVal = k >= rows[i].nE0;
        cyc(1);
        {bpvEvt, hdb3Sub, cvEvt, crcErr, eBitEn} = '0;
        cyc(1);
      end
      tick();
      v = 16'(rows[i].eV);
      c = 10'(rows[i].eR);
      e = 10'(rows[i].eE);
      want = '{v[15:8], v[7:0], {FAS[11:6], c[9:8]}, c[7:0], {FAS[5:0], e[9:8]}, e[7:0]};
      for (k = 0; k < 6; k++) begin
        host_i.rd(ADDR_VIOL_HIGH + 8'(k), d);
        chk(d, want[k]);
      end
    end
    host_i.wr(ADDR_EVENT_MASK, 8'h10);
    for (k = 0; k < 300 && irq2 !== 1'b1; k++) cyc(1);
    chk({7'h00, irq2}, 8'h01);
    host_i.wr(ADDR_EVENT_MASK, 8'h00);
    chk({7'h00, irq2}, 8'h00);
    {fa, sg, cs, violSel, hdb3En, fastUpdate} = '0;
    bpvEvt = 1'b1;
    d = 8'h00;
    for (k = 0; k < 24000 && d !== 8'hFF; k++) host_i.rd(ADDR_VIOL_HIGH, d);
    chk(d, 8'hFF);
    host_i.rd(ADDR_VIOL_LOW, d);
    chk(d, 8'hFF);
    summarize();
  end
endmodule : testbench
